// ---- rtl/esp_regs.vh ----
// Register offsets, field positions, reset values and timing for the sync regulator
`ifndef ESP_REGS_VH
`define ESP_REGS_VH

// Register word offsets (byte address = offset)
`define ESP_REG_CTRL        8'h00
`define ESP_REG_SPD_TC      8'h04
`define ESP_REG_REF_RES     8'h08
`define ESP_REG_REF_TC      8'h0c
`define ESP_REG_REF_CF1     8'h10
`define ESP_REG_REF_CF2     8'h14
`define ESP_REG_SLV_RES     8'h18
`define ESP_REG_SLV_TC      8'h1c
`define ESP_REG_SLV_CF1     8'h20
`define ESP_REG_SLV_CF2     8'h24
`define ESP_REG_SPD_LIMIT   8'h28
`define ESP_REG_MAIN_GAIN   8'h2c
`define ESP_REG_PROP_GAIN   8'h30
`define ESP_REG_POS_LIM     8'h34
`define ESP_REG_NEG_LIM     8'h38
`define ESP_REG_ZGAIN       8'h3c
`define ESP_REG_OFFSET      8'h40
`define ESP_REG_DONE_ANGLE  8'h44
`define ESP_REG_DEV_RANGE   8'h48
`define ESP_REG_TERM_FUNC   8'h4c
`define ESP_REG_STATUS      8'h50
`define ESP_REG_ALARM_CLR   8'h54
`define ESP_REG_SPEED_OUT   8'h58
`define ESP_REG_DEVIATION   8'h5c

// Field positions
`define ESP_CTRL_MODE_LSB   0
`define ESP_CTRL_RUN_BIT    2
`define ESP_STAT_ALARM_BIT  0
`define ESP_STAT_SYNC_BIT   1
`define ESP_STAT_OUTEN_BIT  2

// Mode encodings
`define ESP_MODE_SPEED      2'h0
`define ESP_MODE_STANDBY    2'h1
`define ESP_MODE_SIMUL      2'h2

// Reset values, fixed gain and function codes
`define ESP_RST_PROP_GAIN   16'h05dc
`define ESP_RST_LIMIT       16'h03e7
`define ESP_RST_ZGAIN       16'h000a
`define ESP_RST_DONE_ANGLE  16'h000f
`define ESP_RST_DEV_RANGE   16'hffff
`define ESP_RST_SPD_LIMIT   16'h2710
`define ESP_RST_RES         16'h0400
`define ESP_RST_CF          16'h0001
`define ESP_MAIN_GAIN_X10   16'h000a
`define ESP_TERM_SYNC_FUNC  8'h1d
`define ESP_LIMIT_OFF       16'h03e7

// Timing
`define ESP_CLK_MHZ         125
`define ESP_SAMPLE_US       1000
// Counts are sized literals so they meet the 24-bit counters without truncation
`define ESP_SAMPLE_CYCLES   24'h01e848
`define ESP_SYNC_HOLD_MS    100
`define ESP_SYNC_HOLD_CYCLES 24'hbebc20

`endif

// ---- rtl/esp_quad.v ----
// Quadrature decoder with position counter and Z-phase pulse
`timescale 1ns/100ps
module esp_quad #(
  parameter W = 24
) (
  input  wire                clk,
  input  wire                sys_rst,
  input  wire                phaseA,
  input  wire                phaseB,
  input  wire                phaseZ,
  output reg  signed [W-1:0] count_q,
  output reg                 zPulse_q
);
  reg [1:0] ab_q;
  reg       z_q;
  wire [3:0] tr = {ab_q, phaseA, phaseB};

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      // Seed from the pins so leaving reset gives no false step or Z edge
      ab_q     <= {phaseA, phaseB};
      z_q      <= phaseZ;
      count_q  <= {W{1'b0}};
      zPulse_q <= 1'b0;
    end
    else
    begin
      ab_q     <= {phaseA, phaseB};
      z_q      <= phaseZ;
      zPulse_q <= phaseZ & ~z_q;
      // Four counts per line; illegal double steps are dropped
      case (tr)
        4'b0001, 4'b0111, 4'b1110, 4'b1000: count_q <= count_q + 1'b1;
        4'b0010, 4'b1011, 4'b1101, 4'b0100: count_q <= count_q - 1'b1;
        default:                            count_q <= count_q;
      endcase
    end
  end
endmodule // esp_quad

// ---- rtl/esp_lpf.v ----
// First-order low-pass filter, time constant as a power-of-two shift
`timescale 1ns/100ps
module esp_lpf #(
  parameter W = 24
) (
  input  wire                clk,
  input  wire                sys_rst,
  input  wire                sampleEn,
  input  wire        [3:0]   tcShift,
  input  wire signed [W-1:0] x,
  output wire signed [W-1:0] y
);
  // Sixteen fraction bits keep small inputs from stalling at large shifts
  reg  signed [W+15:0] acc_q;
  wire signed [W+15:0] xs   = {x, 16'h0000};
  wire signed [W+15:0] step = (xs - acc_q) >>> tcShift;

  always @(posedge clk)
  begin
    if (sys_rst)
      acc_q <= {(W+16){1'b0}};
    else if (sampleEn)
      acc_q <= acc_q + step;
  end

  assign y = acc_q[W+15:16];
endmodule // esp_lpf

// ---- rtl/esp_top.v ----
// Encoder synchronous position regulator with Avalon-MM register slave
// Summary of operation
// - Mode 0 speed sync without Z; modes 1 and 2 position sync using Z.
// - Reference resolution zero means use the slave resolution.
// - Pulse-train speed command passes a first-order low-pass filter.
// - Reference and slave feedback each have their own low-pass filter.
// - Shaft speed is encoder speed times factor two over factor one.
// - Both reference factors zero means the slave factors apply instead.
// - Speed controller output clamps to a percent of maximum speed.
// - Main speed gain is fixed at 1.0, not writable.
// - Position gain 1.0 gives max output at deviation of max pulse rate.
// - Position output has positive and negative limits; 999 disables one.
// - Z gain 1.0 gives max output at ten percent of max pulse rate.
// - Standby mode offsets the slave Z target by the offset angle.
// - Sync done when running in mode 1 or 2, deviation within completion angle and terminal set 29.
// - Sync done output stays on for 100 ms once raised.
// - Deviation over 100 times the range raises alarm and stops output.
`timescale 1ns/100ps
`include "esp_regs.vh"
module esp_top #(
  parameter        W            = 24,
  parameter [15:0] MAX_RATE     = 16'd30,
  parameter [23:0] SAMPLE_CYC   = `ESP_SAMPLE_CYCLES,
  parameter [23:0] SYNC_HOLD    = `ESP_SYNC_HOLD_CYCLES
) (
  input  wire                clk,
  input  wire                sys_rst,
  input  wire [7:0]          avs_address,
  input  wire                avs_read,
  input  wire                avs_write,
  input  wire [31:0]         avs_writedata,
  output reg  [31:0]         avs_readdata,
  output reg                 avs_waitrequest,
  input  wire                refA,
  input  wire                refB,
  input  wire                refZ,
  input  wire                slvA,
  input  wire                slvB,
  input  wire                slvZ,
  output reg  signed [W-1:0] speedOut_q,
  output reg                 outEnable_q,
  output reg                 sync_done_out_q,
  output reg                 alarm_q
);
  // Settings
  reg [1:0]  sync_mode_select_q;
  reg        run_q;
  reg [3:0]  speed_cmd_filter_tc_q;
  reg [15:0] ref_encoder_resolution_q;
  reg [3:0]  ref_feedback_filter_tc_q;
  reg [15:0] ref_count_factor_one_q;
  reg [15:0] ref_count_factor_two_q;
  reg [15:0] slave_encoder_resolution_q;
  reg [3:0]  slave_feedback_filter_tc_q;
  reg [15:0] slave_count_factor_one_q;
  reg [15:0] slave_count_factor_two_q;
  reg [15:0] speed_ctrl_output_limit_q;
  reg [15:0] pos_reg_prop_gain_q;
  reg [15:0] pos_reg_pos_limit_q;
  reg [15:0] pos_reg_neg_limit_q;
  reg [15:0] zphase_align_gain_q;
  reg [15:0] sync_offset_angle_q;
  reg [15:0] sync_done_angle_q;
  reg [15:0] deviation_alarm_range_q;
  reg [7:0]  out_terminal_func_a_q;
  reg [7:0]  out_terminal_func_b_q;
  reg [7:0]  out_terminal_func_c_q;

  // Bus handshake
  wire       req    = (avs_read | avs_write) & avs_waitrequest;
  wire       take   = (avs_read | avs_write) & ~avs_waitrequest;
  wire       wrTake = avs_write & take;
  wire       alarmClrWr = wrTake & (avs_address == `ESP_REG_ALARM_CLR) & avs_writedata[0];

  // Sample divider
  reg [23:0] sampleCnt_q;
  reg        sampleEn_q;
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sampleCnt_q <= 24'h000000;
      sampleEn_q  <= 1'b0;
    end
    else if (sampleCnt_q == SAMPLE_CYC - 24'h000001)
    begin
      sampleCnt_q <= 24'h000000;
      sampleEn_q  <= 1'b1;
    end
    else
    begin
      sampleCnt_q <= sampleCnt_q + 24'h000001;
      sampleEn_q  <= 1'b0;
    end
  end

  // Encoders
  wire signed [W-1:0] refCount;
  wire signed [W-1:0] slvCount;
  wire                refZPulse;
  wire                slvZPulse;
  esp_quad #(.W(W)) uRefQuad (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .phaseA   (refA),
    .phaseB   (refB),
    .phaseZ   (refZ),
    .count_q  (refCount),
    .zPulse_q (refZPulse)
  );
  esp_quad #(.W(W)) uSlvQuad (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .phaseA   (slvA),
    .phaseB   (slvB),
    .phaseZ   (slvZ),
    .count_q  (slvCount),
    .zPulse_q (slvZPulse)
  );

  wire [15:0] refRes = (ref_encoder_resolution_q == 16'h0000) ?
                       slave_encoder_resolution_q : ref_encoder_resolution_q;
  wire        refCfZero = (ref_count_factor_one_q == 16'h0000) &
                          (ref_count_factor_two_q == 16'h0000);
  wire [15:0] refCf1 = refCfZero ? slave_count_factor_one_q : ref_count_factor_one_q;
  wire [15:0] refCf2 = refCfZero ? slave_count_factor_two_q : ref_count_factor_two_q;

  function signed [W-1:0] scaleRatio;
    input signed [W-1:0] d;
    input        [15:0]  num;
    input        [15:0]  den;
    reg   signed [W+17:0] p;
    reg   signed [W+17:0] q;
    begin
      p = d * $signed({1'b0, num});
      if (den == 16'h0000)
        q = {(W+18){1'b0}};
      else
        q = p / $signed({1'b0, den});
      scaleRatio = q[W-1:0];
    end
  endfunction

  reg signed [W-1:0] refLast_q;
  reg signed [W-1:0] slvLast_q;
  reg signed [W-1:0] refScaled_q;
  reg signed [W-1:0] slvScaled_q;
  reg signed [31:0]  refPos_q;
  reg signed [31:0]  slvPos_q;
  reg signed [31:0]  refZPos_q;
  reg signed [31:0]  slvZPos_q;
  always @(posedge clk)
  begin
    if (sys_rst | ~run_q)
    begin
      refLast_q   <= refCount;
      slvLast_q   <= slvCount;
      refScaled_q <= {W{1'b0}};
      slvScaled_q <= {W{1'b0}};
      refPos_q    <= 32'h00000000;
      slvPos_q    <= 32'h00000000;
      refZPos_q   <= 32'h00000000;
      slvZPos_q   <= 32'h00000000;
    end
    else
    begin
      if (sampleEn_q)
      begin
        refLast_q   <= refCount;
        slvLast_q   <= slvCount;
        refScaled_q <= scaleRatio(refCount - refLast_q, refCf2, refCf1);
        slvScaled_q <= scaleRatio(slvCount - slvLast_q, slave_count_factor_two_q,
                                  slave_count_factor_one_q);
        refPos_q    <= refPos_q + {{(32-W){refScaled_q[W-1]}}, refScaled_q};
        slvPos_q    <= slvPos_q + {{(32-W){slvScaled_q[W-1]}}, slvScaled_q};
      end
      if (refZPulse)
        refZPos_q <= refPos_q;
      if (slvZPulse)
        slvZPos_q <= slvPos_q;
    end
  end

  wire signed [W-1:0] cmdFilt;
  wire signed [W-1:0] refFb;
  wire signed [W-1:0] slvFb;
  esp_lpf #(.W(W)) uCmdLpf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .sampleEn (sampleEn_q),
    .tcShift  (speed_cmd_filter_tc_q),
    .x        (refScaled_q),
    .y        (cmdFilt)
  );
  esp_lpf #(.W(W)) uRefLpf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .sampleEn (sampleEn_q),
    .tcShift  (ref_feedback_filter_tc_q),
    .x        (refScaled_q),
    .y        (refFb)
  );
  esp_lpf #(.W(W)) uSlvLpf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .sampleEn (sampleEn_q),
    .tcShift  (slave_feedback_filter_tc_q),
    .x        (slvScaled_q),
    .y        (slvFb)
  );

  // mode decode; equal resolution is assumed in position modes
  wire posMode   = (sync_mode_select_q == `ESP_MODE_STANDBY) |
                   (sync_mode_select_q == `ESP_MODE_SIMUL);
  wire signed [31:0] dev    = posMode ? (refPos_q - slvPos_q) : 32'sh0;
  wire        [31:0] devAbs = dev[31] ? (32'h0 - dev) : dev;
  // offset in counts; one turn is four counts per line
  wire        [31:0] offPulses = (sync_offset_angle_q * refRes) / 32'd90;
  wire signed [31:0] zErrRaw = (refPos_q - refZPos_q) - (slvPos_q - slvZPos_q);
  wire signed [31:0] zErr = ~posMode ? 32'sh0 :
                           (sync_mode_select_q == `ESP_MODE_STANDBY) ?
                           zErrRaw - $signed(offPulses) : zErrRaw;

  wire signed [47:0] aprP = (dev * $signed({1'b0, pos_reg_prop_gain_q})) / 48'sd100;
  wire signed [47:0] aprZ = zErr * $signed({1'b0, zphase_align_gain_q});
  wire signed [47:0] aprRaw = aprP + aprZ;

  wire        [W-1:0] refFbAbs = refFb[W-1] ? ({W{1'b0}} - refFb) : refFb;
  wire signed [47:0]  posLim = $signed({24'h0, refFbAbs} * pos_reg_pos_limit_q / 48'd100);
  wire signed [47:0]  negLim = $signed({24'h0, refFbAbs} * pos_reg_neg_limit_q / 48'd100);
  wire posOff = (pos_reg_pos_limit_q == `ESP_LIMIT_OFF);
  wire negOff = (pos_reg_neg_limit_q == `ESP_LIMIT_OFF);
  wire signed [47:0] aprLim = (!posOff && aprRaw > posLim) ? posLim :
                              (!negOff && aprRaw < -negLim) ? -negLim : aprRaw;

  wire signed [47:0] spdRef = {{(48-W){cmdFilt[W-1]}}, cmdFilt} + aprLim;
  wire signed [47:0] spdErr = spdRef - {{(48-W){slvFb[W-1]}}, slvFb};
  wire signed [47:0] spdRaw = spdRef +
                              (spdErr * $signed({1'b0, `ESP_MAIN_GAIN_X10})) / 48'sd10;
  wire signed [47:0] spdLim = $signed({32'h0, MAX_RATE} * speed_ctrl_output_limit_q
                                      / 48'd10000);
  wire signed [47:0] spdClamp = (spdRaw > spdLim) ? spdLim :
                                (spdRaw < -spdLim) ? -spdLim : spdRaw;

  // alarm range is in tenths, so 100x setting is 10x raw
  wire devExcess = posMode & (devAbs > {12'h000, deviation_alarm_range_q, 4'h0} / 32'd16
                                       * 32'd10);
  wire [31:0] devDeg = (refRes == 16'h0000) ? 32'h0 : (devAbs * 32'd90) / refRes;
  wire termHit = (out_terminal_func_a_q == `ESP_TERM_SYNC_FUNC) |
                 (out_terminal_func_b_q == `ESP_TERM_SYNC_FUNC) |
                 (out_terminal_func_c_q == `ESP_TERM_SYNC_FUNC);
  wire syncCond = run_q & posMode & termHit & (devDeg <= {16'h0, sync_done_angle_q});

  reg [23:0] holdCnt_q;
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      holdCnt_q       <= 24'h000000;
      sync_done_out_q <= 1'b0;
      alarm_q         <= 1'b0;
      outEnable_q     <= 1'b0;
      speedOut_q      <= {W{1'b0}};
    end
    else
    begin
      if (syncCond)
        holdCnt_q <= SYNC_HOLD;
      else if (holdCnt_q != 24'h000000)
        holdCnt_q <= holdCnt_q - 24'h000001;
      sync_done_out_q <= syncCond | (holdCnt_q > 24'h000001);
      // latched until cleared; a new excess wins over the clear
      if (run_q & devExcess)
        alarm_q <= 1'b1;
      else if (alarmClrWr)
        alarm_q <= 1'b0;
      outEnable_q <= run_q & ~alarm_q & ~(run_q & devExcess);
      if (run_q & ~alarm_q & ~devExcess)
        speedOut_q <= spdClamp[W-1:0];
      else
        speedOut_q <= {W{1'b0}};
    end
  end

  // Register writes and read mux
  reg [31:0] rdMux;
  always @*
  begin
    rdMux = 32'h00000000;
    case (avs_address)
      `ESP_REG_CTRL:       rdMux = {29'h0, run_q, sync_mode_select_q};
      `ESP_REG_SPD_TC:     rdMux = {28'h0, speed_cmd_filter_tc_q};
      `ESP_REG_REF_RES:    rdMux = {16'h0, ref_encoder_resolution_q};
      `ESP_REG_REF_TC:     rdMux = {28'h0, ref_feedback_filter_tc_q};
      `ESP_REG_REF_CF1:    rdMux = {16'h0, ref_count_factor_one_q};
      `ESP_REG_REF_CF2:    rdMux = {16'h0, ref_count_factor_two_q};
      `ESP_REG_SLV_RES:    rdMux = {16'h0, slave_encoder_resolution_q};
      `ESP_REG_SLV_TC:     rdMux = {28'h0, slave_feedback_filter_tc_q};
      `ESP_REG_SLV_CF1:    rdMux = {16'h0, slave_count_factor_one_q};
      `ESP_REG_SLV_CF2:    rdMux = {16'h0, slave_count_factor_two_q};
      `ESP_REG_SPD_LIMIT:  rdMux = {16'h0, speed_ctrl_output_limit_q};
      `ESP_REG_MAIN_GAIN:  rdMux = {16'h0, `ESP_MAIN_GAIN_X10};
      `ESP_REG_PROP_GAIN:  rdMux = {16'h0, pos_reg_prop_gain_q};
      `ESP_REG_POS_LIM:    rdMux = {16'h0, pos_reg_pos_limit_q};
      `ESP_REG_NEG_LIM:    rdMux = {16'h0, pos_reg_neg_limit_q};
      `ESP_REG_ZGAIN:      rdMux = {16'h0, zphase_align_gain_q};
      `ESP_REG_OFFSET:     rdMux = {16'h0, sync_offset_angle_q};
      `ESP_REG_DONE_ANGLE: rdMux = {16'h0, sync_done_angle_q};
      `ESP_REG_DEV_RANGE:  rdMux = {16'h0, deviation_alarm_range_q};
      `ESP_REG_TERM_FUNC:  rdMux = {8'h0, out_terminal_func_c_q, out_terminal_func_b_q,
                                    out_terminal_func_a_q};
      `ESP_REG_STATUS:     rdMux = {29'h0, outEnable_q, sync_done_out_q, alarm_q};
      `ESP_REG_SPEED_OUT:  rdMux = {{(32-W){speedOut_q[W-1]}}, speedOut_q};
      `ESP_REG_DEVIATION:  rdMux = dev;
      default:             rdMux = 32'h00000000;
    endcase
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      avs_waitrequest            <= 1'b1;
      avs_readdata               <= 32'h00000000;
      sync_mode_select_q         <= `ESP_MODE_SPEED;
      run_q                      <= 1'b0;
      speed_cmd_filter_tc_q      <= 4'h0;
      ref_encoder_resolution_q   <= 16'h0000;
      ref_feedback_filter_tc_q   <= 4'h0;
      ref_count_factor_one_q     <= 16'h0000;
      ref_count_factor_two_q     <= 16'h0000;
      slave_encoder_resolution_q <= `ESP_RST_RES;
      slave_feedback_filter_tc_q <= 4'h0;
      slave_count_factor_one_q   <= `ESP_RST_CF;
      slave_count_factor_two_q   <= `ESP_RST_CF;
      speed_ctrl_output_limit_q  <= `ESP_RST_SPD_LIMIT;
      pos_reg_prop_gain_q        <= `ESP_RST_PROP_GAIN;
      pos_reg_pos_limit_q        <= `ESP_RST_LIMIT;
      pos_reg_neg_limit_q        <= `ESP_RST_LIMIT;
      zphase_align_gain_q        <= `ESP_RST_ZGAIN;
      sync_offset_angle_q        <= 16'h0000;
      sync_done_angle_q          <= `ESP_RST_DONE_ANGLE;
      deviation_alarm_range_q    <= `ESP_RST_DEV_RANGE;
      out_terminal_func_a_q      <= 8'h00;
      out_terminal_func_b_q      <= 8'h00;
      out_terminal_func_c_q      <= 8'h00;
    end
    else
    begin
      // One wait cycle, then a single acknowledge cycle
      avs_waitrequest <= ~req;
      if (req)
        avs_readdata <= rdMux;
      if (wrTake)
      begin
        case (avs_address)
          `ESP_REG_CTRL:
          begin
            sync_mode_select_q <= avs_writedata[1:0];
            run_q              <= avs_writedata[`ESP_CTRL_RUN_BIT];
          end
          `ESP_REG_SPD_TC:     speed_cmd_filter_tc_q      <= avs_writedata[3:0];
          `ESP_REG_REF_RES:    ref_encoder_resolution_q   <= avs_writedata[15:0];
          `ESP_REG_REF_TC:     ref_feedback_filter_tc_q   <= avs_writedata[3:0];
          `ESP_REG_REF_CF1:    ref_count_factor_one_q     <= avs_writedata[15:0];
          `ESP_REG_REF_CF2:    ref_count_factor_two_q     <= avs_writedata[15:0];
          `ESP_REG_SLV_RES:    slave_encoder_resolution_q <= avs_writedata[15:0];
          `ESP_REG_SLV_TC:     slave_feedback_filter_tc_q <= avs_writedata[3:0];
          `ESP_REG_SLV_CF1:    slave_count_factor_one_q   <= avs_writedata[15:0];
          `ESP_REG_SLV_CF2:    slave_count_factor_two_q   <= avs_writedata[15:0];
          `ESP_REG_SPD_LIMIT:  speed_ctrl_output_limit_q  <= avs_writedata[15:0];
          `ESP_REG_PROP_GAIN:  pos_reg_prop_gain_q        <= avs_writedata[15:0];
          `ESP_REG_POS_LIM:    pos_reg_pos_limit_q        <= avs_writedata[15:0];
          `ESP_REG_NEG_LIM:    pos_reg_neg_limit_q        <= avs_writedata[15:0];
          `ESP_REG_ZGAIN:      zphase_align_gain_q        <= avs_writedata[15:0];
          `ESP_REG_OFFSET:     sync_offset_angle_q        <= avs_writedata[15:0];
          `ESP_REG_DONE_ANGLE: sync_done_angle_q          <= avs_writedata[15:0];
          `ESP_REG_DEV_RANGE:  deviation_alarm_range_q    <= avs_writedata[15:0];
          `ESP_REG_TERM_FUNC:
          begin
            out_terminal_func_a_q <= avs_writedata[7:0];
            out_terminal_func_b_q <= avs_writedata[15:8];
            out_terminal_func_c_q <= avs_writedata[23:16];
          end
          default:
          begin
            run_q <= run_q;
          end
        endcase
      end
    end
  end
endmodule // esp_top

// ---- verif/esp_enc_model.sv ----
// Quadrature encoder model for one motor shaft
`timescale 1ns/100ps
module esp_enc_model #(
  parameter DIV = 8,
  parameter PPR = 16
) (
  input  wire clk,
  input  wire en,
  output wire phA,
  output wire phB,
  output wire phZ
);
  integer div = 0;
  integer pos = 0;
  assign phZ = (pos % (4 * PPR)) == 0;
  assign phA = pos[1];
  assign phB = pos[1] ^ pos[0];
  // Stands still when disabled, like a stopped shaft
  always @(posedge clk)
  begin
    if (en)
      div <= (div == DIV - 1) ? 0 : div + 1;
    if (en && div == DIV - 1)
      pos <= pos + 1;
  end
endmodule // esp_enc_model

// ---- verif/esp_top_monitor.sv ----
// Port checker for the sync regulator, bound to the top module
`timescale 1ns/100ps
module esp_top_monitor #(
  parameter        W         = 24,
  parameter [23:0] SYNC_HOLD = 24'd100
) (
  input wire                clk,
  input wire                sys_rst,
  input wire [7:0]          avs_address,
  input wire                avs_read,
  input wire                avs_write,
  input wire [31:0]         avs_writedata,
  input wire [31:0]         avs_readdata,
  input wire                avs_waitrequest,
  input wire signed [W-1:0] speedOut_q,
  input wire                outEnable_q,
  input wire                sync_done_out_q,
  input wire                alarm_q
);
  reg  [23:0] holdCnt_q;
  reg         termOk_q;
  wire        wrDone = avs_write && !avs_waitrequest;
  wire        rdDone = avs_read && !avs_waitrequest;
  always @(posedge clk)
  begin
    holdCnt_q <= (sys_rst || !sync_done_out_q) ? 24'h0 : holdCnt_q + 24'h1;
    if (sys_rst)
      termOk_q <= 1'b0;
    else if (wrDone && avs_address == 8'h4c)
      termOk_q <= avs_writedata[7:0] == 8'h1d || avs_writedata[15:8] == 8'h1d
                  || avs_writedata[23:16] == 8'h1d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_ACK_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer late");
  AST_ACK_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("ack too long");
  AST_RD_HOLD: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data moved");
  AST_GAIN_FIXED: assert property (rdDone && avs_address == 8'h2c |-> avs_readdata == 32'ha)
    else $error("main gain not fixed");
  AST_UNMAPPED: assert property (rdDone && avs_address > 8'h5c |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_ALARM_OFF: assert property (alarm_q |-> !outEnable_q && speedOut_q == 0)
    else $error("output on during alarm");
  AST_ALARM_HOLD: assert property ($fell(alarm_q) |->
    $past(wrDone && avs_address == 8'h54 && avs_writedata[0])) else $error("alarm dropped");
  AST_SYNC_TERM: assert property ($rose(sync_done_out_q) |-> termOk_q)
    else $error("sync done without terminal");
  // Alarm exempted: shutdown leaves the flag and its hold count running
  AST_SYNC_HOLD: assert property ($fell(sync_done_out_q) && !alarm_q |->
    $past(holdCnt_q) >= SYNC_HOLD - 24'd1) else $error("sync done too short");
  cover property (rdDone);
  cover property ($rose(alarm_q));
  cover property ($fell(sync_done_out_q));
endmodule // esp_top_monitor
bind esp_top esp_top_monitor #(.W(W), .SYNC_HOLD(SYNC_HOLD)) u_esp_top_monitor (.*);

// ---- verif/test_esp_top.sv ----
// Bench for the sync regulator: bus tasks, encoder drive and checks
`timescale 1ns/100ps
module test_esp_top;
  reg                clk = 1'b0;
  reg                sys_rst = 1'b1;
  reg         [7:0]  avs_address = 8'h0;
  reg                avs_read = 1'b0;
  reg                avs_write = 1'b0;
  reg         [31:0] avs_writedata = 32'h0;
  wire        [31:0] avs_readdata;
  wire               avs_waitrequest;
  reg                refEn = 1'b0;
  reg                slvEn = 1'b0;
  wire               refA, refB, refZ, slvA, slvB, slvZ;
  wire signed [23:0] speedOut_q;
  wire               outEnable_q, sync_done_out_q, alarm_q;
  reg         [31:0] rd;
  integer            mismatches = 0;
  integer            checks = 0;
  integer            i;
  reg         [7:0]  ra [0:9] = '{8'h18, 8'h20, 8'h24, 8'h28, 8'h30,
                                  8'h34, 8'h38, 8'h3c, 8'h44, 8'h48};
  reg         [31:0] rv [0:9] = '{32'h400, 32'h1, 32'h1, 32'h2710, 32'h5dc,
                                  32'h3e7, 32'h3e7, 32'ha, 32'hf, 32'hffff};
  // Short counts keep the run small
  esp_top #(.SAMPLE_CYC(24'd50), .SYNC_HOLD(24'd100)) u_esp_top (.*);
  esp_enc_model u_esp_enc_model (.clk(clk), .en(refEn), .phA(refA), .phB(refB), .phZ(refZ));
  esp_enc_model u_esp_enc_model_slv (.clk(clk), .en(slvEn), .phA(slvA), .phB(slvB),
                                     .phZ(slvZ));
  initial
    forever #4 clk = ~clk;
  task final_report;
    begin
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task bus(input wr, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      // Only the watchdog ends a wait that never gets an answer
      do
        @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task rdchk(input [7:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      check(rd, e);
    end
  endtask
  initial
  begin
    #320000;
    mismatches = mismatches + 1;
    final_report;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 10; i = i + 1)
      rdchk(ra[i], rv[i]);
    bus(1'b1, 8'h2c, 32'h55);
    rdchk(8'h2c, 32'ha);
    rdchk(8'h60, 32'h0);
    bus(1'b1, 8'h18, 32'h10);
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h10, 32'h0);
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b1, 8'h4c, 32'h1d);
    bus(1'b1, 8'h28, 32'h3e8);
    refEn <= 1'b1;
    slvEn <= 1'b1;
    for (i = 0; i < 3; i = i + 1)
    begin
      bus(1'b1, 8'h00, 32'h4 | i);
      repeat (200) @(posedge clk);
      check({31'h0, outEnable_q}, 32'h1);
      check({8'h0, speedOut_q}, 32'h3);
    end
    i = 0;
    while (sync_done_out_q !== 1'b1 && i < 5000)
    begin
      @(posedge clk);
      i = i + 1;
    end
    check({31'h0, sync_done_out_q}, 32'h1);
    slvEn <= 1'b0;
    repeat (60) @(posedge clk);
    check({31'h0, sync_done_out_q}, 32'h1);
    bus(1'b1, 8'h48, 32'h0);
    i = 0;
    while (alarm_q !== 1'b1 && i < 2000)
    begin
      @(posedge clk);
      i = i + 1;
    end
    check({30'h0, alarm_q, outEnable_q}, 32'h2);
    check({8'h0, speedOut_q}, 32'h0);
    bus(1'b1, 8'h54, 32'h1);
    repeat (4) @(posedge clk);
    check({31'h0, alarm_q}, 32'h1);
    refEn <= 1'b0;
    bus(1'b1, 8'h00, 32'h2);
    repeat (10) @(posedge clk);
    check({31'h0, alarm_q}, 32'h1);
    bus(1'b1, 8'h54, 32'h1);
    repeat (4) @(posedge clk);
    check({31'h0, alarm_q}, 32'h0);
    repeat (300) @(posedge clk);
    check({31'h0, sync_done_out_q}, 32'h0);
    final_report;
  end
endmodule // test_esp_top
